// File: hdl/asc_host.sv
// Host end: APB-controlled convert strobe, standby and framed serial port.
// Assumes the converter samples pins through two flops in its own clock domain.
// Behaviour
// - strobe rising edge starts hold and conversion
// - conversion end returns sampler to tracking
// - acquisition gap after conversion before strobe
// - strobes no faster than variant throughput
// - standby when pin low or sleep bit
// - wait 2 ms after internal-reference wake
// - wait 5 us after external-reference wake
// - first written bit is control MSB
// - write frame carries eight bits
// - read result as one 16-bit frame
// - frame held low yields second byte
// - both directions shift MSB first
// - clock idles high, data at falling
// - frames active low around each transfer
// - falling end-of-conversion marks completion
// - software start waits before reading
// - result straight binary or twos complement
//
// Decided for this implementation: the register addresses and the APB slave port.
`timescale 1ns/1ps
`include "asc_regs.svh"
module asc_host #(
  parameter int SCLK_HALF    = `ASC_SCLK_HALF,
  parameter int WAKE_INT_CYC = `ASC_T_WAKE_INT_MS * `ASC_NS_PER_MS / `ASC_CLK_NS
) (
  input  wire logic        pclk,     // Clock
  input  wire logic        presetn,  // Reset, low
  input  wire logic        psel,     // APB select
  input  wire logic        penable,  // APB enable
  input  wire logic        pwrite,   // APB write
  input  wire logic [7:0]  paddr,    // APB address
  input  wire logic [31:0] pwdata,   // APB write data
  output logic      [31:0] prdata,   // APB read data
  output logic             pready,   // APB ready
  output logic             pslverr,  // APB error
  output logic             irq,      // Interrupt, high
  asc_link.host            lnk       // Link pins
);
  localparam int PER_B = `ASC_CYC(`ASC_NS_PER_MS / `ASC_F_BIP_KHZ);
  localparam int PER_U = `ASC_CYC(`ASC_NS_PER_MS / `ASC_F_UNI_KHZ);
  localparam int ACQ_B = `ASC_CYC(`ASC_T_ACQ_BIP_NS);
  localparam int ACQ_U = `ASC_CYC(`ASC_T_ACQ_UNI_NS);
  localparam int SWR_B = `ASC_CYC(`ASC_T_SWRD_BIP_NS);
  localparam int SWR_U = `ASC_CYC(`ASC_T_SWRD_UNI_NS);
  localparam int WAKE_X = `ASC_CYC(`ASC_T_WAKE_EXT_US * `ASC_NS_PER_US);
  localparam int STB = `ASC_CYC(`ASC_T_STB_NS);
  localparam int DOUT = 1, EOC = 0;

  asc_pkg::asc_hst_e   st_q;
  logic [1:0]          s1_q, s2_q, s3_q;
  logic [2:0]          cfg_q, pend_q, take, stat_q, mask_q, ev, setp, clr;
  asc_pkg::asc_cword_t cword_q, sent_q;
  asc_pkg::asc_word_t  tx_q, rx_q, result_q;
  asc_pkg::asc_cnt_t   per_q, acq_q, wake_q, swr_q;
  logic [7:0]          hc_q;
  logic [4:0]          bit_q;
  logic                rd_q, sclk_q, din_q, wfr_n_q, rfr_n_q, cnv_n_q;
  logic                sby_n_q, sleep_q;
  logic [31:0]         rdata_d;
  logic                err_d;

  // APB: one wait state, access completes with pready high
  wire acc = psel & penable & pready;
  wire wr  = acc & pwrite;
  always_comb begin
    rdata_d = '0;
    err_d   = 1'b0;
    unique case (paddr)
      `ASC_A_CTRL: begin
        rdata_d[`ASC_C_SLEEP +: 3] = cfg_q;
        rdata_d[`ASC_C_BUSY]       = (st_q != asc_pkg::HS_IDLE) | (|pend_q);
      end
      `ASC_A_CWORD:  rdata_d[`ASC_CW_W-1:0]    = cword_q;
      `ASC_A_RESULT: rdata_d[`ASC_RD_BITS-1:0] = result_q;
      `ASC_A_STATUS: rdata_d[`ASC_S_W-1:0]     = stat_q;
      `ASC_A_MASK:   rdata_d[`ASC_S_W-1:0]     = mask_q;
      default:       err_d = 1'b1;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= '0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & penable & ~pready;
      if (psel & penable & ~pready) begin
        prdata  <= pwrite ? 32'h0000_0000 : rdata_d;
        pslverr <= err_d;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q   <= '0;
      cword_q <= '0;
      mask_q  <= '0;
    end else if (wr) begin
      if (paddr == `ASC_A_CTRL) cfg_q <= pwdata[`ASC_C_SLEEP +: 3];
      if (paddr == `ASC_A_CWORD) cword_q <= pwdata[`ASC_CW_W-1:0];
      if (paddr == `ASC_A_MASK) mask_q <= pwdata[`ASC_S_W-1:0];
    end
  end

  // Link inputs through two flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= 2'h3;
      s2_q <= 2'h3;
      s3_q <= 2'h3;
    end else begin
      s1_q <= {lnk.dout, lnk.conv_done_n};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  wire edge_now = hc_q == 8'(SCLK_HALF - 1);
  wire last_bit = bit_q == (rd_q ? 5'(`ASC_RD_BITS - 1) : 5'(`ASC_WR_BITS - 1));
  wire fin      = st_q == asc_pkg::HS_FRAME && edge_now && !sclk_q && last_bit;
  wire stb_end  = st_q == asc_pkg::HS_STROBE && hc_q == 8'(STB - 1);
  wire sleeping = ~sby_n_q | cfg_q[0] | sleep_q;
  wire can_cv   = per_q == '0 && acq_q == '0 && wake_q == '0 && !sleeping;
  wire idle     = st_q == asc_pkg::HS_IDLE;

  always_comb begin
    take = '0;
    take[`ASC_C_WRITE] = idle & pend_q[`ASC_C_WRITE];
    take[`ASC_C_READ]  = idle & ~pend_q[`ASC_C_WRITE] & pend_q[`ASC_C_READ]
                         & (swr_q == '0);
    take[`ASC_C_CONV]  = idle & ~pend_q[`ASC_C_WRITE] & ~take[`ASC_C_READ]
                         & pend_q[`ASC_C_CONV] & can_cv;
    setp = (wr && paddr == `ASC_A_CTRL) ? pwdata[`ASC_C_READ:`ASC_C_CONV] : 3'h0;
  end

  // Pending commands; a new request wins over its own take
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_q <= '0;
    end else begin
      pend_q <= setp | (pend_q & ~take);
    end
  end

  // Strobe and frame sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q    <= asc_pkg::HS_IDLE;
      hc_q    <= '0;
      bit_q   <= '0;
      rd_q    <= 1'b0;
      tx_q    <= '0;
      rx_q    <= '0;
      sclk_q  <= 1'b1;
      din_q   <= 1'b0;
      wfr_n_q <= 1'b1;
      rfr_n_q <= 1'b1;
      cnv_n_q <= 1'b1;
      sent_q  <= '0;
    end else begin
      unique case (st_q)
        asc_pkg::HS_IDLE: begin
          hc_q  <= '0;
          bit_q <= '0;
          if (take[`ASC_C_WRITE]) begin
            st_q    <= asc_pkg::HS_FRAME;
            rd_q    <= 1'b0;
            sent_q  <= cword_q;
            tx_q    <= {cword_q, 10'h000};
            din_q   <= cword_q[`ASC_CW_W-1];
            wfr_n_q <= 1'b0;
          end else if (take[`ASC_C_READ]) begin
            st_q    <= asc_pkg::HS_FRAME;
            rd_q    <= 1'b1;
            rfr_n_q <= 1'b0;
          end else if (take[`ASC_C_CONV]) begin
            st_q    <= asc_pkg::HS_STROBE;
            cnv_n_q <= 1'b0;
          end
        end
        asc_pkg::HS_STROBE: begin
          hc_q <= hc_q + 8'h01;
          if (stb_end) begin
            st_q    <= asc_pkg::HS_IDLE;
            cnv_n_q <= 1'b1;
          end
        end
        asc_pkg::HS_FRAME: begin
          hc_q <= edge_now ? 8'h00 : hc_q + 8'h01;
          if (edge_now && sclk_q) begin
            sclk_q <= 1'b0;
            rx_q   <= {rx_q[`ASC_RD_BITS-2:0], s2_q[DOUT]};
          end else if (edge_now) begin
            sclk_q <= 1'b1;
            bit_q  <= bit_q + 5'h01;
            tx_q   <= {tx_q[`ASC_RD_BITS-2:0], 1'b0};
            din_q  <= tx_q[`ASC_RD_BITS-2];
            if (last_bit) begin
              st_q    <= asc_pkg::HS_IDLE;
              wfr_n_q <= 1'b1;
              rfr_n_q <= 1'b1;
              din_q   <= 1'b0;
            end
          end
        end
      endcase
    end
  end

  // Hold-off timers
  wire fin_up  = st_q == asc_pkg::HS_FRAME && edge_now && !sclk_q && last_bit;
  wire eoc_ev  = s3_q[EOC] & ~s2_q[EOC];
  wire wake_ev = (~cfg_q[0] & ~sby_n_q)
                 | (fin_up & ~rd_q & sleep_q & ~sent_q[`ASC_CW_SLEEP]);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      per_q   <= '0;
      acq_q   <= '0;
      wake_q  <= '0;
      swr_q   <= '0;
      sleep_q <= 1'b0;
      sby_n_q <= 1'b1;
    end else begin
      sby_n_q <= ~cfg_q[0];
      if (fin_up && !rd_q) sleep_q <= sent_q[`ASC_CW_SLEEP];
      if (stb_end) per_q <= asc_pkg::asc_cnt_t'(cfg_q[1] ? PER_B : PER_U);
      else if (per_q != '0) per_q <= per_q - 18'h1;
      if (eoc_ev) acq_q <= asc_pkg::asc_cnt_t'(cfg_q[1] ? ACQ_B : ACQ_U);
      else if (acq_q != '0) acq_q <= acq_q - 18'h1;
      if (wake_ev) wake_q <= asc_pkg::asc_cnt_t'(cfg_q[2] ? WAKE_X : WAKE_INT_CYC);
      else if (wake_q != '0) wake_q <= wake_q - 18'h1;
      if (fin_up && !rd_q && sent_q[`ASC_CW_SWCNV])
        swr_q <= asc_pkg::asc_cnt_t'(cfg_q[1] ? SWR_B : SWR_U);
      else if (swr_q != '0) swr_q <= swr_q - 18'h1;
    end
  end

  // Sticky status, write one to clear, event wins
  always_comb begin
    ev = '0;
    ev[`ASC_S_EOC] = eoc_ev;
    ev[`ASC_S_WR]  = fin & ~rd_q;
    ev[`ASC_S_RD]  = fin & rd_q;
    clr = (wr && paddr == `ASC_A_STATUS) ? pwdata[`ASC_S_W-1:0] : 3'h0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_q   <= '0;
      irq      <= 1'b0;
      result_q <= '0;
    end else begin
      stat_q <= ev | (stat_q & ~clr);
      irq    <= |(stat_q & mask_q);
      if (fin && rd_q) result_q <= rx_q;
    end
  end

  assign lnk.sclk             = sclk_q;
  assign lnk.din              = din_q;
  assign lnk.transmit_frame_n = wfr_n_q;
  assign lnk.receive_frame_n  = rfr_n_q;
  assign lnk.convert_strobe_n = cnv_n_q;
  assign lnk.standby_n        = sby_n_q;
endmodule : asc_host

// File: hdl/asc_regs.svh
// Timing, control word and host register constants of the converter link.
// Included by the package and both ends; holds definitions only.
`ifndef ASC_REGS_SVH
`define ASC_REGS_SVH
`define ASC_CLK_NS         10
`define ASC_NS_PER_US      1000
`define ASC_NS_PER_MS      1000000
`define ASC_CYC(ns)        (((ns) + `ASC_CLK_NS - 1) / `ASC_CLK_NS)
`define ASC_T_CONV_NS      1600
`define ASC_T_ACQ_BIP_NS   600
`define ASC_T_ACQ_UNI_NS   400
`define ASC_F_BIP_KHZ      454
`define ASC_F_UNI_KHZ      500
`define ASC_T_WAKE_INT_MS  2
`define ASC_T_WAKE_EXT_US  5
`define ASC_T_SWRD_BIP_NS  2200
`define ASC_T_SWRD_UNI_NS  2000
`define ASC_T_STB_NS       40
`define ASC_SCLK_HALF      8
`define ASC_CW_W           6
`define ASC_CW_CH          0
`define ASC_CW_CH_W        3
`define ASC_CW_FMT         3
`define ASC_CW_SLEEP       4
`define ASC_CW_SWCNV       5
`define ASC_WR_BITS        8
`define ASC_RD_BITS        16
`define ASC_CODE_W         12
`define ASC_FMT_FLIP       12'h800
`define ASC_A_CTRL         8'h00
`define ASC_A_CWORD        8'h04
`define ASC_A_RESULT       8'h08
`define ASC_A_STATUS       8'h0C
`define ASC_A_MASK         8'h10
`define ASC_C_CONV         0
`define ASC_C_WRITE        1
`define ASC_C_READ         2
`define ASC_C_SLEEP        3
`define ASC_C_BIP          4
`define ASC_C_EXT          5
`define ASC_C_BUSY         8
`define ASC_S_EOC          0
`define ASC_S_WR           1
`define ASC_S_RD           2
`define ASC_S_W            3
`endif

// File: hdl/asc_pkg.sv
// Types shared by both ends of the converter link.
// Relies on asc_regs.svh for the code, control word and result widths.
`include "asc_regs.svh"
package asc_pkg;
  typedef logic [17:0]               asc_cnt_t;
  typedef logic [`ASC_CODE_W-1:0]    asc_code_t;
  typedef logic [`ASC_CW_W-1:0]      asc_cword_t;
  typedef logic [`ASC_RD_BITS-1:0]   asc_word_t;
  typedef enum logic [1:0] {HS_IDLE, HS_STROBE, HS_FRAME} asc_hst_e;
endpackage : asc_pkg

// File: hdl/asc_link.sv
// Pins between the converter and its host; all single-direction.
// Each end runs its own pclk and samples every pin through two flops.
`timescale 1ns/1ps
interface asc_link;
  logic sclk;              // Serial clock, idle high
  logic din;               // Host to converter data
  logic dout;              // Converter to host data
  logic transmit_frame_n;  // Write frame, active low
  logic receive_frame_n;   // Read frame, active low
  logic convert_strobe_n;  // Convert strobe, active low
  logic standby_n;         // Standby pin, low sleeps
  logic conv_done_n;       // End of conversion, active low
  modport dev (input sclk, din, transmit_frame_n, receive_frame_n,
               convert_strobe_n, standby_n, output dout, conv_done_n);
  modport host (output sclk, din, transmit_frame_n, receive_frame_n,
                convert_strobe_n, standby_n, input dout, conv_done_n);
endinterface : asc_link

// File: hdl/asc_dev.sv
// Converter end: conversion sequencing, standby and serial port.
// Assumes a host keeping acquisition, rate and frame discipline.
`timescale 1ns/1ps
`include "asc_regs.svh"
module asc_dev #(
  parameter int CONV_CYC = `ASC_CYC(`ASC_T_CONV_NS)
) (
  input  wire logic                            pclk,      // Clock
  input  wire logic                            presetn,   // Reset, low
  asc_link.dev                                 lnk,       // Link pins
  input  wire logic [7:0][`ASC_CODE_W-1:0]     ch_data,   // Channel codes
  output logic      [`ASC_CW_CH_W-1:0]         chan_sel,  // Channel chosen
  output logic                                 tracking,  // Sampler tracks
  output logic                                 standby,   // In standby
  output asc_pkg::asc_code_t                   result     // Last result
);
  localparam int SCK = 5, DIN = 4, WFR = 3, RFR = 2, CNV = 1, SBY = 0;
  logic [5:0]          s1_q, s2_q, s3_q;
  asc_pkg::asc_cword_t ctrl_q, wsh_q;
  logic [3:0]          wcnt_q;
  logic                go_q, conv_q, done_n_q, dout_q;
  asc_pkg::asc_cnt_t   cnt_q;
  asc_pkg::asc_code_t  held_q;
  asc_pkg::asc_word_t  rsh_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= 6'h3F;
      s2_q <= 6'h3F;
      s3_q <= 6'h3F;
    end else begin
      s1_q <= {lnk.sclk, lnk.din, lnk.transmit_frame_n, lnk.receive_frame_n,
               lnk.convert_strobe_n, lnk.standby_n};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  wire sck_fall = s3_q[SCK] & ~s2_q[SCK];
  wire sck_rise = ~s3_q[SCK] & s2_q[SCK];
  wire wfr_rise = ~s3_q[WFR] & s2_q[WFR];
  wire rfr_fall = s3_q[RFR] & ~s2_q[RFR];
  wire cnv_rise = ~s3_q[CNV] & s2_q[CNV];

  // Control word capture; only the first six bits count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wsh_q  <= '0;
      wcnt_q <= '0;
      ctrl_q <= '0;
      go_q   <= 1'b0;
    end else begin
      go_q <= 1'b0;
      if (s2_q[WFR]) begin
        wcnt_q <= '0;
      end else if (sck_fall && wcnt_q < 4'(`ASC_CW_W)) begin
        wsh_q  <= {wsh_q[`ASC_CW_W-2:0], s2_q[DIN]};
        wcnt_q <= wcnt_q + 4'h1;
      end
      if (wfr_rise && wcnt_q == 4'(`ASC_CW_W)) begin
        ctrl_q <= wsh_q;
        go_q   <= wsh_q[`ASC_CW_SWCNV];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      standby <= 1'b1;
    end else begin
      standby <= ~s2_q[SBY] | ctrl_q[`ASC_CW_SLEEP];
    end
  end

  // Conversion: strobe rising edge holds, end returns to track
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_q   <= 1'b0;
      tracking <= 1'b1;
      cnt_q    <= '0;
      held_q   <= '0;
      result   <= '0;
      done_n_q <= 1'b1;
      chan_sel <= '0;
    end else if (conv_q) begin
      cnt_q <= cnt_q + 18'h1;
      if (cnt_q == asc_pkg::asc_cnt_t'(CONV_CYC - 1)) begin
        conv_q   <= 1'b0;
        tracking <= 1'b1;
        done_n_q <= 1'b0;
        result   <= ctrl_q[`ASC_CW_FMT] ? held_q ^ `ASC_FMT_FLIP : held_q;
      end
    end else if ((cnv_rise || go_q) && !standby) begin
      conv_q   <= 1'b1;
      tracking <= 1'b0;
      cnt_q    <= '0;
      done_n_q <= 1'b1;
      chan_sel <= ctrl_q[`ASC_CW_CH +: `ASC_CW_CH_W];
      held_q   <= ch_data[ctrl_q[`ASC_CW_CH +: `ASC_CW_CH_W]];
    end
  end

  // Result word: zero, channel, code; MSB leads, shifts at rising clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rsh_q  <= '0;
      dout_q <= 1'b0;
    end else if (rfr_fall) begin
      rsh_q  <= {1'b0, chan_sel, result};
      dout_q <= 1'b0;
    end else if (s2_q[RFR]) begin
      dout_q <= 1'b0;
    end else if (sck_rise) begin
      rsh_q  <= {rsh_q[`ASC_RD_BITS-2:0], 1'b0};
      dout_q <= rsh_q[`ASC_RD_BITS-2];
    end
  end

  assign lnk.dout        = dout_q;
  assign lnk.conv_done_n = done_n_q;
endmodule : asc_dev

// File: bench/asc_link_sva.sv
// Concurrent checks on the pins between host and converter ends.
// Instantiated beside the link in the bench; both ends share one pclk.
`timescale 1ns/1ps
module asc_link_sva #(
  parameter int CONV_CYC = 160
) (
  input wire logic pclk,             // Clock
  input wire logic presetn,          // Reset, low
  input wire logic sclk,             // Serial clock
  input wire logic din,              // Host data
  input wire logic dout,             // Converter data
  input wire logic transmit_frame_n, // Write frame
  input wire logic receive_frame_n,  // Read frame
  input wire logic convert_strobe_n, // Convert strobe
  input wire logic standby_n,        // Standby pin
  input wire logic conv_done_n       // Done, low
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [9:0] since_cnv_q; // Cycles since strobe rise
  logic [9:0] since_eoc_q; // Cycles since done fell
  logic [4:0] falls_q;     // Falling sclk edges in frame
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) since_cnv_q <= 10'h3FF;
    else if ($rose(convert_strobe_n)) since_cnv_q <= 10'h000;
    else if (since_cnv_q != 10'h3FF) since_cnv_q <= since_cnv_q + 10'h001;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) since_eoc_q <= 10'h3FF;
    else if ($fell(conv_done_n)) since_eoc_q <= 10'h000;
    else if (since_eoc_q != 10'h3FF) since_eoc_q <= since_eoc_q + 10'h001;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) falls_q <= 5'h00;
    else if (transmit_frame_n && receive_frame_n) falls_q <= 5'h00;
    else if ($fell(sclk)) falls_q <= falls_q + 5'h01;
  end
  sequence strobe_low_s;
    !convert_strobe_n [*4] ##1 convert_strobe_n;
  endsequence
  sequence sclk_low_s;
    !sclk [*8] ##1 sclk;
  endsequence
  AST_STROBE_WIDTH: assert property ($fell(convert_strobe_n) |-> strobe_low_s)
    else $error("strobe low width wrong");
  AST_STROBE_AWAKE: assert property ($fell(convert_strobe_n) |-> standby_n)
    else $error("strobe issued while standby pin low");
  AST_DONE_RELEASE: assert property ($rose(convert_strobe_n) && !conv_done_n |-> ##[1:6] conv_done_n)
    else $error("done not released at conversion start");
  AST_DONE_LATENCY: assert property ($fell(conv_done_n) |->
    since_cnv_q >= CONV_CYC - 1 && since_cnv_q <= CONV_CYC + 4)
    else $error("conversion time wrong");
  AST_RATE: assert property ($rose(convert_strobe_n) |-> since_cnv_q >= 10'd199)
    else $error("strobes too close");
  AST_ACQ: assert property ($rose(convert_strobe_n) |-> since_eoc_q >= 10'd39)
    else $error("acquisition gap too short");
  AST_SCLK_IDLE: assert property (transmit_frame_n && receive_frame_n |-> sclk)
    else $error("serial clock not idle high");
  AST_SCLK_HALF: assert property ($fell(sclk) |-> sclk_low_s)
    else $error("serial clock low phase wrong");
  AST_FRAMES_APART: assert property (transmit_frame_n || receive_frame_n)
    else $error("frames overlap");
  AST_WRITE_BITS: assert property ($rose(transmit_frame_n) |-> falls_q == 5'd8)
    else $error("write frame length wrong");
  AST_READ_BITS: assert property ($rose(receive_frame_n) |-> falls_q == 5'd16)
    else $error("read frame length wrong");
  AST_DOUT_QUIET: assert property (receive_frame_n [*4] |-> !dout)
    else $error("data out active outside read frame");
  AST_DIN_SETTLED: assert property (!transmit_frame_n && $changed(din) |->
    $rose(sclk) || $fell(transmit_frame_n))
    else $error("data in changed off the rising clock");
endmodule : asc_link_sva

// File: bench/adc_serial_conversion_control_bench.sv
// Self-checking bench: host and converter ends joined by the link.
// Drives APB into the host and random channel codes into the converter.
`timescale 1ns/1ps
`include "asc_regs.svh"
module adc_serial_conversion_control_bench;
  localparam int CONV = `ASC_CYC(`ASC_T_CONV_NS);
  logic                        pclk, presetn, psel, penable, pwrite;
  logic [7:0]                  paddr;
  logic [31:0]                 pwdata, prdata, cfg;
  logic                        pready, pslverr, irq, tracking, standby, fmt, sclk_p, tf_p, rf_p;
  logic [7:0][`ASC_CODE_W-1:0] ch_data;
  logic [2:0]                  chan_sel, ch;
  asc_pkg::asc_code_t          result, code;
  asc_pkg::asc_cword_t         cw;
  logic [32:0]                 exp_q[$], e;
  logic [15:0]                 rd_q[$], sh;
  logic [7:0]                  wr_q[$];
  int                          err_count, n_checks, frames, want, seed;
  time                         t0;
  asc_link lnk();
  asc_host #(.WAKE_INT_CYC(300)) i_asc_host(.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .lnk(lnk.host));
  asc_dev #(.CONV_CYC(CONV)) i_asc_dev(.pclk(pclk), .presetn(presetn), .lnk(lnk.dev),
    .ch_data(ch_data), .chan_sel(chan_sel), .tracking(tracking), .standby(standby),
    .result(result));
  asc_link_sva #(.CONV_CYC(CONV)) i_asc_link_sva(.pclk(pclk), .presetn(presetn),
    .sclk(lnk.sclk), .din(lnk.din), .dout(lnk.dout), .transmit_frame_n(lnk.transmit_frame_n),
    .receive_frame_n(lnk.receive_frame_n), .convert_strobe_n(lnk.convert_strobe_n),
    .standby_n(lnk.standby_n), .conv_done_n(lnk.conv_done_n));
  initial pclk = 1'b0;
  always #5 pclk = ~pclk;
  task automatic check(input string what, input logic [32:0] seen, input logic [32:0] expv);
    n_checks++;
    if (seen !== expv) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, expv, seen);
    end
  endtask : check
  task automatic end_of_test;
    if (err_count == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_of_test
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [32:0] x);
    int n;
    exp_q.push_back(x);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) check("pready", pready, 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0, {1'b0, x});
  endtask : rd
  function automatic bit hit(input int k);
    case (k)
      0: return irq === 1'b1;
      1: return lnk.convert_strobe_n === 1'b0;
      2: return lnk.convert_strobe_n === 1'b1;
      default: return frames >= want;
    endcase
  endfunction : hit
  task automatic wait_on(input int k);
    int n;
    n = 0;
    while (!hit(k) && n < 4000) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 4000) check("wait", k, 33'h1FFFFFFFF);
  endtask : wait_on
  task automatic send_cword(input asc_pkg::asc_cword_t c, input logic [31:0] ctl);
    wr(`ASC_A_CWORD, 32'(c));
    wr_q.push_back({c, 2'b00});
    want = frames + 1;
    wr(`ASC_A_CTRL, ctl | 32'h2);
    wait_on(3);
    repeat (4) @(posedge pclk);
  endtask : send_cword
  // Completed APB transfers against the oldest note
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      e = exp_q.pop_front();
      check("pslverr", pslverr, e[32]);
      if (!pwrite && !e[32]) check("prdata", prdata, e[31:0]);
    end
  end
  // Wire monitor: bits taken at falling serial clock
  always @(posedge pclk) begin
    sclk_p <= lnk.sclk;
    tf_p   <= lnk.transmit_frame_n;
    rf_p   <= lnk.receive_frame_n;
    if (sclk_p && !lnk.sclk && !lnk.transmit_frame_n) sh <= {sh[14:0], lnk.din};
    if (sclk_p && !lnk.sclk && !lnk.receive_frame_n) sh <= {sh[14:0], lnk.dout};
    if (!tf_p && lnk.transmit_frame_n) begin
      frames++;
      check("written bits", sh[7:0], wr_q.pop_front());
    end
    if (!rf_p && lnk.receive_frame_n) begin
      frames++;
      check("read bits", sh, rd_q.pop_front());
    end
  end
  initial begin
    #1000000;
    err_count++;
    end_of_test();
  end
  initial begin
    seed = 32'h0dae;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    for (int k = 0; k < 8; k++) ch_data[k] = 12'($random(seed));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    check("tracking", tracking, 1'b1);
    rd(`ASC_A_CTRL, 32'h0);
    rd(`ASC_A_STATUS, 32'h0);
    rd(`ASC_A_RESULT, 32'h0);
    apb(1'b0, 8'h14, 32'h0, {1'b1, 32'h0});
    // Soft sleep with status masked, then unmasked
    wr(`ASC_A_MASK, 32'h0);
    send_cword(6'h10, 32'h0);
    check("irq masked", irq, 1'b0);
    check("soft standby", standby, 1'b1);
    rd(`ASC_A_STATUS, 32'h2);
    wr(`ASC_A_MASK, 32'h2);
    repeat (3) @(posedge pclk);
    check("irq", irq, 1'b1);
    wr(`ASC_A_STATUS, 32'h2);
    repeat (3) @(posedge pclk);
    check("irq cleared", irq, 1'b0);
    send_cword(6'h00, 32'h0);
    check("awake", standby, 1'b0);
    wr(`ASC_A_STATUS, 32'h2);
    wr(`ASC_A_MASK, 32'h7);
    rd(`ASC_A_MASK, 32'h7);
    for (int i = 0; i < 4; i++) begin
      ch = 3'($random(seed));
      fmt = i[0];
      cfg = (32'(i[1]) << 4) | (i == 3 ? 32'h20 : 32'h0);
      cw = {2'b00, fmt, ch};
      code = ch_data[ch] ^ (fmt ? `ASC_FMT_FLIP : 12'h000);
      send_cword(cw, cfg);
      rd(`ASC_A_STATUS, 32'h2);
      wr(`ASC_A_STATUS, 32'h2);
      wr(`ASC_A_CTRL, cfg | 32'h1);
      wait_on(1);
      wait_on(2);
      repeat (5) @(posedge pclk);
      check("holding", tracking, 1'b0);
      wait_on(0);
      @(posedge pclk);
      check("tracking", tracking, 1'b1);
      check("chan_sel", chan_sel, ch);
      check("result", result, code);
      rd(`ASC_A_STATUS, 32'h1);
      wr(`ASC_A_STATUS, 32'h1);
      rd_q.push_back({1'b0, ch, code});
      wr(`ASC_A_CTRL, cfg | 32'h4);
      wait_on(0);
      rd(`ASC_A_RESULT, {17'h0, ch, code});
      rd(`ASC_A_STATUS, 32'h4);
      wr(`ASC_A_STATUS, 32'h4);
      rd(`ASC_A_CTRL, cfg);
    end
    // Second strobe requested at once after completion
    wr(`ASC_A_STATUS, 32'h7);
    wr(`ASC_A_CTRL, 32'h10);
    wr(`ASC_A_CTRL, 32'h11);
    wait_on(0);
    wr(`ASC_A_STATUS, 32'h1);
    wr(`ASC_A_CTRL, 32'h11);
    wait_on(1);
    wait_on(0);
    wr(`ASC_A_STATUS, 32'h1);
    // Pin sleep, then wake before converting
    wr(`ASC_A_CTRL, 32'h8);
    repeat (6) @(posedge pclk);
    check("pin standby", standby, 1'b1);
    wr(`ASC_A_CTRL, 32'h0);
    t0 = $time;
    wr(`ASC_A_CTRL, 32'h1);
    wait_on(1);
    check("wake wait", ($time - t0) >= 3000, 1'b1);
    wait_on(0);
    wr(`ASC_A_STATUS, 32'h1);
    repeat (10) @(posedge pclk);
    check("notes left", exp_q.size() + wr_q.size() + rd_q.size(), 33'h0);
    end_of_test();
  end
endmodule : adc_serial_conversion_control_bench
